// ---- rtl/dswc_consts.svh ----
/*
  Register offsets, bit positions, reset values and timing counts of the
  doze, sleep and wake controller.
  Assumes inclusion by its bare name from the package and the top module.
*/
`ifndef DSWC_CONSTS_SVH
`define DSWC_CONSTS_SVH

// Register offsets on the plain register port
`define DSWC_ADR_CTRL   4'h0
`define DSWC_ADR_RSTEN  4'h1
`define DSWC_ADR_STAT   4'h2
`define DSWC_ADR_ISTAT  4'h3
`define DSWC_ADR_IMASK  4'h4

// Control register fields
`define DSWC_CTL_RATIO_HI 2
`define DSWC_CTL_RATIO_LO 0
`define DSWC_CTL_DOZE     3
`define DSWC_CTL_ROI      4
`define DSWC_CTL_DOE      5

// Reset source enables, also the index into the synchroniser vector
`define DSWC_RS_MASTER_CLEAR_PIN   0
`define DSWC_RS_BOR    1
`define DSWC_RS_LOW_POWER_BROWN_OUT_RESET  2
`define DSWC_RS_POR    3
`define DSWC_RS_WDT    4
// Watchdog enable bit; power-on has no enable, so it sits one lower
`define DSWC_EN_WDT    3

// Status register fields
`define DSWC_ST_PD     0
`define DSWC_ST_TO     1
`define DSWC_ST_ASLEEP 2
`define DSWC_ST_WAIT   3

// Event status and mask fields
`define DSWC_EV_WAKE   0
`define DSWC_EV_RESET  1
`define DSWC_EV_NOP    2
`define DSWC_EV_SLEPT  3

// Reset values
`define DSWC_CTRL_RST  8'h00
`define DSWC_RSTEN_RST 4'hf
`define DSWC_IMASK_RST 4'h0
`define DSWC_SYNC_RST  5'h01

// Clock switch interrupt never wakes the core
`define DSWC_CLKSW_BIT 7

// Instruction cycle is four oscillator cycles
`define DSWC_PHASE_LAST 2'h3
`define DSWC_PREFETCH_STEP 16'h0002

`endif

// ---- rtl/dswc_pkg.sv ----
/*
  Types of the doze, sleep and wake controller: power state, carriers for
  the register port, the core events, the readiness inputs and the state.
  Assumes the constants header sits beside it.
*/
`include "dswc_consts.svh"

package dswc_pkg;

  typedef enum logic [2:0] {
    DSWC_RUN   = 3'b001,
    DSWC_SLEEP = 3'b010,
    DSWC_WAIT  = 3'b100
  } dswc_pwr_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dswc_bus_t;

  typedef struct packed {
    logic        isr_entry;
    logic        isr_return;
    logic        sleep_exec;
    logic        global_interrupt_enable;
    logic [15:0] pc;
  } dswc_core_t;

  typedef struct packed {
    logic flash_ready;
    logic osc_ready;
    logic bor_ready;
    logic bor_disabled;
  } dswc_rdy_t;

  typedef struct packed {
    logic [1:0]  phase;
    logic [7:0]  dz_cnt;
    logic [7:0]  ctrl;
    logic [3:0]  rsten;
    logic [3:0]  istat;
    logic [3:0]  imask;
    logic        pd;
    logic        to;
    dswc_pwr_t   pwr;
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic        cpu_active;
    logic        instr_tick;
    logic        wdt_clear;
    logic        dev_reset;
    logic        resume;
    logic        vector;
    logic [15:0] prefetch_pc;
    logic [7:0]  rdata;
    logic        irq;
  } dswc_state_t;

endpackage

// ---- rtl/dswc_top.sv ----
/*
  Doze, sleep and wake controller for a small CPU core: doze duty cycle,
  doze handling across interrupt entry and return, sleep entry, wake by
  interrupt, reset wake sources and the readiness gate before resuming.
  Assumes core events and interrupt flags come from sys_clk logic; reset
  source pins arrive asynchronously and are synchronised here.
*/
// Operation
// - With doze on, CPU runs one instruction cycle in every N, N from ratio.
// - Oscillator and quarter-rate instruction clock run unchanged during doze.
// - Recover-on-interrupt and doze-on-exit decide doze across interrupts.
// - ISR entry copies doze enable to doze-on-exit; without recover, doze kept.
// - With recover set, ISR entry clears doze enable; ISR runs full rate.
// - Interrupt return loads doze enable from doze-on-exit.
// - Software may write doze-on-exit in the ISR; return uses that value.
// - Ratio 001 gives one active instruction cycle then three idle ones.
// - Any enabled interrupt except clock switch wakes; execution continues.
// - Master clear, brown-out, low-power brown-out, power-on, watchdog reset.
// - Sleep instruction prefetches the instruction at program counter plus 2.
// - Wake needs the source enable set; global enable does not matter.
// - After wake run next instruction; vector to ISR if global enable set.
// - Watchdog is cleared on every interrupt wake from sleep.
// - Resume waits for flash, current oscillator and brown-out readiness.
// - Pending enabled interrupt makes sleep a no-op; no flag or watchdog change.
// - Sleep taken: clear watchdog, set timeout flag, clear power-down flag.
`timescale 1ns/1ps
`include "dswc_consts.svh"

module dswc_top
  import dswc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Register port
  input  wire dswc_bus_t  bus,
  output logic [7:0]      rdata,
  output logic            irq,
  // Core events
  input  wire dswc_core_t core,
  input  wire logic [7:0] irq_flags,
  input  wire logic [7:0] irq_enables,
  input  wire dswc_rdy_t  rdy,
  // Asynchronous reset sources
  input  wire logic       master_clear_pin_n,
  input  wire logic       brown_out_reset,
  input  wire logic       low_power_brown_out_reset,
  input  wire logic       power_on_reset,
  input  wire logic       window_watchdog_event,
  // Core controls
  output logic            cpu_active,
  output logic            instr_tick,
  output logic            window_watchdog_clear,
  output logic            device_reset,
  output logic            resume,
  output logic            isr_vector,
  output logic [15:0]     prefetch_pc,
  output logic            doze_enable,
  output logic            timeout_flag,
  output logic            power_down_flag
);

  dswc_state_t s_q;
  dswc_state_t s_d;

  logic [4:0] rst_src;
  logic [7:0] wake_src;
  logic       wake_pend;
  logic       tick;
  logic [8:0] dz_span;
  logic [7:0] dz_last;
  logic [4:0] rst_ev;
  logic [3:0] ev_set;
  logic [3:0] ev_clr;
  logic       ready;

  assign rst_src = {window_watchdog_event, power_on_reset, low_power_brown_out_reset,
                    brown_out_reset, master_clear_pin_n};

  // Global enable plays no part; clock switch source masked out
  assign wake_src  = irq_flags & irq_enables;
  assign wake_pend = |(wake_src & ~(8'h01 << `DSWC_CLKSW_BIT));

  assign tick    = (s_q.phase == `DSWC_PHASE_LAST);
  // N = 2 << ratio, so 001 gives 1:4
  assign dz_span = 9'h002 << s_q.ctrl[`DSWC_CTL_RATIO_HI:`DSWC_CTL_RATIO_LO];
  assign dz_last = dz_span[7:0] - 8'h01;

  assign ready = rdy.flash_ready & rdy.osc_ready &
                 (rdy.bor_ready | rdy.bor_disabled);

  // Only the second synchroniser stage is looked at
  assign rst_ev[`DSWC_RS_MASTER_CLEAR_PIN]  = ~s_q.sync2[`DSWC_RS_MASTER_CLEAR_PIN] & s_q.rsten[`DSWC_RS_MASTER_CLEAR_PIN];
  assign rst_ev[`DSWC_RS_BOR]   = s_q.sync2[`DSWC_RS_BOR] & s_q.rsten[`DSWC_RS_BOR];
  assign rst_ev[`DSWC_RS_LOW_POWER_BROWN_OUT_RESET] = s_q.sync2[`DSWC_RS_LOW_POWER_BROWN_OUT_RESET] & s_q.rsten[`DSWC_RS_LOW_POWER_BROWN_OUT_RESET];
  assign rst_ev[`DSWC_RS_POR]   = s_q.sync2[`DSWC_RS_POR];
  assign rst_ev[`DSWC_RS_WDT]   = s_q.sync2[`DSWC_RS_WDT] & s_q.rsten[`DSWC_EN_WDT];

  always_comb begin
    s_d            = s_q;
    ev_set         = 4'h0;
    ev_clr         = 4'h0;
    s_d.wdt_clear  = 1'b0;
    s_d.resume     = 1'b0;
    s_d.vector     = 1'b0;
    s_d.rdata      = 8'h00;
    s_d.sync1      = rst_src;
    s_d.sync2      = s_q.sync1;

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        `DSWC_ADR_CTRL:  s_d.ctrl  = bus.wdata;
        `DSWC_ADR_RSTEN: s_d.rsten = bus.wdata[3:0];
        `DSWC_ADR_ISTAT: ev_clr    = bus.wdata[3:0];
        `DSWC_ADR_IMASK: s_d.imask = bus.wdata[3:0];
        default: ;
      endcase
    end

    // Hardware updates override a software write in the same cycle
    if (core.isr_entry) begin
      s_d.ctrl[`DSWC_CTL_DOE] = s_q.ctrl[`DSWC_CTL_DOZE];
      if (s_q.ctrl[`DSWC_CTL_ROI]) begin
        s_d.ctrl[`DSWC_CTL_DOZE] = 1'b0;
      end
    end
    if (core.isr_return) begin
      s_d.ctrl[`DSWC_CTL_DOZE] = s_q.ctrl[`DSWC_CTL_DOE];
    end

    // Instruction phase never stops, doze or not
    s_d.phase      = s_q.phase + 2'h1;
    s_d.instr_tick = tick;

    if (!s_q.ctrl[`DSWC_CTL_DOZE]) begin
      s_d.dz_cnt = 8'h00;
    end else if (tick) begin
      s_d.dz_cnt = (s_q.dz_cnt == dz_last) ? 8'h00 : s_q.dz_cnt + 8'h01;
    end

    // Fetch and execute only in the active doze slot
    s_d.cpu_active = tick && (s_q.pwr == DSWC_RUN) &&
                     (!s_q.ctrl[`DSWC_CTL_DOZE] || s_q.dz_cnt == 8'h00);

    unique case (s_q.pwr)
      DSWC_RUN: begin
        if (core.sleep_exec) begin
          s_d.prefetch_pc = core.pc + `DSWC_PREFETCH_STEP;
          if (wake_pend) begin
            ev_set[`DSWC_EV_NOP] = 1'b1;
          end else begin
            s_d.pwr       = DSWC_SLEEP;
            s_d.pd        = 1'b0;
            s_d.to        = 1'b1;
            s_d.wdt_clear = 1'b1;
            ev_set[`DSWC_EV_SLEPT] = 1'b1;
          end
        end
      end
      DSWC_SLEEP: begin
        if (wake_pend) begin
          s_d.pwr       = DSWC_WAIT;
          s_d.wdt_clear = 1'b1;
          ev_set[`DSWC_EV_WAKE] = 1'b1;
        end
      end
      DSWC_WAIT: begin
        if (ready) begin
          s_d.pwr    = DSWC_RUN;
          s_d.resume = 1'b1;
          s_d.vector = core.global_interrupt_enable;
        end
      end
      default: s_d.pwr = DSWC_RUN;
    endcase

    // Any enabled reset source, asleep or awake, resets the device
    s_d.dev_reset = |rst_ev;
    if (|rst_ev) begin
      s_d.pwr    = DSWC_RUN;
      s_d.pd     = 1'b1;
      s_d.to     = 1'b1;
      s_d.resume = 1'b0;
      s_d.vector = 1'b0;
      ev_set[`DSWC_EV_RESET] = 1'b1;
    end

    // Set wins over a write-one clear in the same cycle
    s_d.istat = (s_q.istat & ~ev_clr) | ev_set;
    s_d.irq   = |(s_d.istat & s_d.imask);

    if (bus.rd) begin
      case (bus.addr)
        `DSWC_ADR_CTRL:  s_d.rdata = s_q.ctrl;
        `DSWC_ADR_RSTEN: s_d.rdata = {4'h0, s_q.rsten};
        `DSWC_ADR_STAT:  s_d.rdata = {4'h0, s_q.pwr == DSWC_WAIT,
                                      s_q.pwr == DSWC_SLEEP, s_q.to, s_q.pd};
        `DSWC_ADR_ISTAT: s_d.rdata = {4'h0, s_q.istat};
        `DSWC_ADR_IMASK: s_d.rdata = {4'h0, s_q.imask};
        default:         s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q             <= '0;
      s_q.ctrl        <= `DSWC_CTRL_RST;
      s_q.rsten       <= `DSWC_RSTEN_RST;
      s_q.imask       <= `DSWC_IMASK_RST;
      s_q.pd          <= 1'b1;
      s_q.to          <= 1'b1;
      s_q.pwr         <= DSWC_RUN;
      s_q.sync1       <= `DSWC_SYNC_RST;
      s_q.sync2       <= `DSWC_SYNC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata                 = s_q.rdata;
  assign irq                   = s_q.irq;
  assign cpu_active            = s_q.cpu_active;
  assign instr_tick            = s_q.instr_tick;
  assign window_watchdog_clear = s_q.wdt_clear;
  assign device_reset          = s_q.dev_reset;
  assign resume                = s_q.resume;
  assign isr_vector            = s_q.vector;
  assign prefetch_pc           = s_q.prefetch_pc;
  assign doze_enable           = s_q.ctrl[`DSWC_CTL_DOZE];
  assign timeout_flag          = s_q.to;
  assign power_down_flag       = s_q.pd;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic ctl_wr;
  logic quiet;
  assign ctl_wr = bus.wr && (bus.addr == `DSWC_ADR_CTRL);
  assign quiet  = !core.isr_entry && !core.isr_return && !ctl_wr;

  sequence doze_1to4_s;
    cpu_active && doze_enable && s_q.ctrl[2:0] == 3'h1 && quiet;
  endsequence

  // A write or isr event inside the gap legally restarts the slot count
  sequence doze_calm_s;
    (doze_enable && s_q.ctrl[2:0] == 3'h1 && quiet) [*8];
  endsequence

  doze_gap_a: assert property (
    doze_1to4_s ##1 doze_calm_s |->
      !cpu_active && !$past(cpu_active) && !$past(cpu_active, 2) &&
      !$past(cpu_active, 3) && !$past(cpu_active, 4) &&
      !$past(cpu_active, 5) && !$past(cpu_active, 6) && !$past(cpu_active, 7))
    else $error("active cycle inside doze idle slots");

  tick_steady_a: assert property (
    instr_tick |-> ##1 !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick not every four cycles");

  isr_copy_a: assert property (
    core.isr_entry && !core.isr_return |=>
      s_q.ctrl[`DSWC_CTL_DOE] == $past(doze_enable))
    else $error("doze-on-exit not loaded on isr entry");

  isr_keep_a: assert property (
    core.isr_entry && !core.isr_return && !s_q.ctrl[`DSWC_CTL_ROI] && !ctl_wr |=>
      doze_enable == $past(doze_enable))
    else $error("doze enable changed on isr entry without recover");

  isr_recover_a: assert property (
    core.isr_entry && !core.isr_return && s_q.ctrl[`DSWC_CTL_ROI] |=> !doze_enable)
    else $error("doze enable not cleared with recover set");

  isr_return_a: assert property (
    core.isr_return |=> doze_enable == $past(s_q.ctrl[`DSWC_CTL_DOE]))
    else $error("doze enable not loaded from doze-on-exit");

  sleep_nop_a: assert property (
    core.sleep_exec && wake_pend && s_q.pwr == DSWC_RUN && !(|rst_ev) |=>
      s_q.pwr == DSWC_RUN && power_down_flag == $past(power_down_flag) &&
      timeout_flag == $past(timeout_flag) && !window_watchdog_clear)
    else $error("sleep no-op altered state");

  sleep_take_a: assert property (
    core.sleep_exec && !wake_pend && s_q.pwr == DSWC_RUN && !(|rst_ev) |=>
      !power_down_flag && timeout_flag && window_watchdog_clear &&
      s_q.pwr == DSWC_SLEEP)
    else $error("sleep entry flags wrong");

  wake_clear_a: assert property (
    s_q.pwr == DSWC_SLEEP && wake_pend && !(|rst_ev) |=>
      window_watchdog_clear && s_q.pwr == DSWC_WAIT)
    else $error("wake did not clear watchdog");

  resume_gate_a: assert property (
    $rose(resume) |-> $past(ready) && $past(s_q.pwr == DSWC_WAIT))
    else $error("resume without readiness");

  vector_gie_a: assert property (
    isr_vector |-> resume && $past(core.global_interrupt_enable))
    else $error("vector without global enable");

  reset_src_a: assert property (
    |rst_ev |=> device_reset && s_q.pwr == DSWC_RUN)
    else $error("reset source ignored");

  idle_sleep_a: assert property (
    s_q.pwr != DSWC_RUN && $past(s_q.pwr != DSWC_RUN) |-> !cpu_active)
    else $error("cpu active while asleep");

  prefetch_a: assert property (
    core.sleep_exec && s_q.pwr == DSWC_RUN |=>
      prefetch_pc == $past(core.pc) + 16'h0002)
    else $error("prefetch address wrong");

  ev_keep_a: assert property (
    s_q.istat[`DSWC_EV_NOP] && !(bus.wr && bus.addr == `DSWC_ADR_ISTAT) |=>
      s_q.istat[`DSWC_EV_NOP])
    else $error("sticky event lost");

  rdata_idle_a: assert property (
    !bus.rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");

  wake_event_a: assert property (
    s_q.pwr == DSWC_SLEEP && wake_pend && !(|rst_ev) |=> s_q.istat[`DSWC_EV_WAKE])
    else $error("wake event not recorded");

  nop_event_a: assert property (
    core.sleep_exec && wake_pend && s_q.pwr == DSWC_RUN |=> s_q.istat[`DSWC_EV_NOP])
    else $error("sleep no-op event not recorded");

  reset_event_a: assert property (
    |rst_ev |=> s_q.istat[`DSWC_EV_RESET] && power_down_flag && timeout_flag)
    else $error("reset source event or flags wrong");

  wait_hold_a: assert property (
    s_q.pwr == DSWC_WAIT && !ready && !(|rst_ev) |=> s_q.pwr == DSWC_WAIT && !resume)
    else $error("left readiness wait early");

  resume_pulse_a: assert property (
    resume |=> !resume)
    else $error("resume longer than one cycle");

  doze_enable_hold_a: assert property (
    quiet |=> doze_enable == $past(doze_enable))
    else $error("doze enable changed without cause");

  doe_hold_a: assert property (
    !core.isr_entry && !ctl_wr |=>
      s_q.ctrl[`DSWC_CTL_DOE] == $past(s_q.ctrl[`DSWC_CTL_DOE]))
    else $error("doze-on-exit changed without cause");

  active_tick_a: assert property (
    cpu_active |-> instr_tick)
    else $error("active cycle off the instruction tick");

  wait_idle_a: assert property (
    s_q.pwr != DSWC_RUN |=> !cpu_active)
    else $error("cpu active before resume");

  sleep_stay_a: assert property (
    s_q.pwr == DSWC_SLEEP && !wake_pend && !(|rst_ev) |=>
      s_q.pwr == DSWC_SLEEP && !window_watchdog_clear)
    else $error("left sleep without a wake source");

  no_vector_a: assert property (
    resume && !$past(core.global_interrupt_enable) |-> !isr_vector)
    else $error("vector with global enable clear");

endmodule // dswc_top

// ---- verification/dswc_far_model.sv ----
/*
  Far-side model of the readiness sources: flash, oscillator, brown-out.
  Assumes sleep entry and wake both show as watchdog clear pulses.
*/
`timescale 1ns/1ps
module dswc_far_model
  import dswc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Observed controls
  input  wire logic       wdt_clear,
  input  wire logic       dev_reset,
  // Scenario knobs
  input  wire logic [3:0] delay,
  input  wire logic       bor_off,
  // Readiness
  output dswc_rdy_t       rdy
);
  logic       asleep_q;
  logic [3:0] cnt_q;
  logic       up;

  // Clocks stop in sleep; readiness returns after the wake delay, or at once on device reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      asleep_q <= 1'b0;
      cnt_q    <= 4'h0;
    end else if (dev_reset) begin
      asleep_q <= 1'b0;
      cnt_q    <= 4'h0;
    end else if (wdt_clear) begin
      asleep_q <= !asleep_q;
      cnt_q    <= delay;
    end else if (!asleep_q && cnt_q != 4'h0) begin
      cnt_q    <= cnt_q - 4'h1;
    end
  end

  assign up = !asleep_q && cnt_q == 4'h0;
  // Disabled brown-out never reports ready, as the real one would not
  assign rdy = '{up, up, up && !bor_off, bor_off};
endmodule // dswc_far_model

// ---- verification/dswc_top_tb.sv ----
/*
  Self-checking bench of the doze, sleep and wake controller.
  Assumes the far-side model supplies readiness; bench drives the rest.
*/
`timescale 1ns/1ps
module dswc_top_tb;
  import dswc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  dswc_bus_t   bus = '0;
  dswc_core_t  core = '0;
  logic [7:0]  irq_flags = 8'h00;
  logic [7:0]  irq_enables = 8'h00;
  logic [4:0]  src = 5'h00;
  logic [3:0]  dly = 4'h0;
  logic        bor_off = 1'b0;
  dswc_rdy_t   rdy;
  logic [7:0]  rdata;
  logic        irq, cpu_active, instr_tick, wdt_clr, dev_rst, resume, isr_vector;
  logic        doze_en, to_f, pd_f;
  logic [15:0] prefetch_pc;
  logic [15:0] lfsr_q = 16'hdcef;
  int          err_total, n_tests, n_wdt;

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wdt_clr === 1'b1) n_wdt++;

  dswc_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .bus(bus), .rdata(rdata), .irq(irq),
    .core(core), .irq_flags(irq_flags), .irq_enables(irq_enables), .rdy(rdy),
    .master_clear_pin_n(~src[0]), .brown_out_reset(src[1]),
    .low_power_brown_out_reset(src[2]), .power_on_reset(src[3]),
    .window_watchdog_event(src[4]), .cpu_active(cpu_active), .instr_tick(instr_tick),
    .window_watchdog_clear(wdt_clr), .device_reset(dev_rst), .resume(resume),
    .isr_vector(isr_vector), .prefetch_pc(prefetch_pc), .doze_enable(doze_en),
    .timeout_flag(to_f), .power_down_flag(pd_f));

  dswc_far_model u_far (.sys_clk(sys_clk), .nrst(nrst), .wdt_clear(wdt_clr),
    .dev_reset(dev_rst), .delay(dly), .bor_off(bor_off), .rdy(rdy));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask

  // Bits: isr_entry, isr_return, sleep_exec; results checked one edge later
  task automatic pulse(input logic [2:0] p);
    @(posedge sys_clk);
    core[19:17] <= p;
    @(posedge sys_clk);
    core[19:17] <= 3'b000;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_resume(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 200; i++) begin
      @(posedge sys_clk);
      #1;
      if (resume === 1'b1) return;
      ok = rdy.flash_ready & rdy.osc_ready & (rdy.bor_ready | rdy.bor_disabled);
    end
    err_total++;
    $display("Error resume expected 1 seen 0");
    finish_test();
  endtask

  initial begin
    #1000000;
    err_total++;
    $display("Error run expected done seen hung");
    finish_test();
  end

  initial begin : main
    logic [7:0] s;
    logic [3:0] k;
    logic       ok;
    int         c, t;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(4'h0, 8'h00, "ctrl reset");
    rd(4'h1, 8'h0f, "rsten reset");
    rd(4'h2, 8'h03, "stat reset");
    rd(4'h9, 8'h00, "unmapped read");
    // Pending enabled flag turns sleep into a no-op
    @(posedge sys_clk);
    irq_flags   <= 8'h01;
    irq_enables <= 8'h01;
    c = n_wdt;
    pulse(3'b001);
    chk("pd nop", 1, pd_f);
    chk("wdt nop", c[15:0], n_wdt[15:0]);
    rd(4'h2, 8'h03, "stat nop");
    rd(4'h3, 8'h04, "evstat nop");
    wr(4'h3, 8'h0f);
    $display("test nop done");
    for (k = 0; k < 5; k++) begin
      wr(4'h0, k == 4 ? 8'h00 : {5'h01, k[2:0]});
      cycles(40);
      c = 0;
      t = 0;
      repeat (128) begin
        @(posedge sys_clk);
        #1;
        c += int'(cpu_active);
        t += int'(instr_tick);
      end
      chk("active count", k == 4 ? 16'd32 : 16'd16 >> k, c[15:0]);
      chk("tick count", 16'd32, t[15:0]);
    end
    $display("test doze done");
    for (k = 0; k < 4; k++) begin
      wr(4'h0, {3'b000, k[1], k[0], 3'b001});
      pulse(3'b100);
      chk("doze_enable entry", k[0] & ~k[1], doze_en);
      rd(4'h0, {2'b00, k[0], k[1], k[0] & ~k[1], 3'b001}, "ctrl entry");
      lfsr_q = lfsr(lfsr_q);
      wr(4'h0, {2'b00, lfsr_q[0], k[1], k[0] & ~k[1], 3'b001});
      pulse(3'b010);
      chk("doze_enable return", lfsr_q[0], doze_en);
    end
    wr(4'h0, 8'h00);
    $display("test isr done");
    for (k = 0; k < 2; k++) begin
      lfsr_q = lfsr(lfsr_q);
      s = 8'h01 << (lfsr_q[10:8] == 3'h7 ? 3'h0 : lfsr_q[10:8]);
      @(posedge sys_clk);
      irq_flags   <= 8'h80 | (~s & 8'h7f);
      irq_enables <= 8'h80 | s;
      core.pc     <= lfsr_q;
      core.global_interrupt_enable    <= lfsr_q[4];
      dly         <= k[0] ? 4'h6 : 4'h0;
      bor_off     <= k[0];
      wr(4'h4, {7'h00, k[0]});
      c = n_wdt;
      pulse(3'b001);
      chk("pd sleep", 0, pd_f);
      chk("to sleep", 1, to_f);
      chk("prefetch", lfsr_q + 16'h0002, prefetch_pc);
      t = 0;
      repeat (12) begin
        @(posedge sys_clk);
        #1;
        t += int'(cpu_active);
      end
      chk("asleep active", 0, t[15:0]);
      @(posedge sys_clk);
      irq_flags <= 8'hff;
      wait_resume(ok);
      chk("ready before resume", 1, ok);
      chk("vector", lfsr_q[4], isr_vector);
      chk("wdt wake", c[15:0] + 16'd2, n_wdt[15:0]);
      cycles(2);
      chk("irq masked", k[0], irq);
      rd(4'h3, 8'h09, "evstat wake");
      wr(4'h3, 8'h0f);
      cycles(1);
      chk("irq cleared", 0, irq);
      @(posedge sys_clk);
      irq_flags <= 8'h00;
    end
    $display("test wake done");
    for (k = 0; k < 5; k++) begin
      pulse(3'b001);
      @(posedge sys_clk);
      src <= 5'h01 << k;
      cycles(4);
      chk("device reset", 1, dev_rst);
      rd(4'h2, 8'h03, "stat reset wake");
      @(posedge sys_clk);
      src <= 5'h00;
      cycles(5);
      chk("device reset off", 0, dev_rst);
    end
    wr(4'h1, 8'h0d);
    rd(4'h1, 8'h0d, "rsten write");
    @(posedge sys_clk);
    src <= 5'h02;
    cycles(5);
    chk("disabled reset", 0, dev_rst);
    @(posedge sys_clk);
    src <= 5'h00;
    $display("test reset sources done");
    finish_test();
  end
endmodule // dswc_top_tb
